// ---- inc/mids_map.vh ----
`ifndef MIDS_MAP_VH
`define MIDS_MAP_VH
// device-type code; the value is arbitrary, chosen for this block only
`define MIDS_TYPE_CODE   4'h6
`define MIDS_TYPE_W      4
`define MIDS_STRAP_W     3
`define MIDS_ADDR_W      8
`define MIDS_DATA_W      8
`define MIDS_DEPTH       256
`define MIDS_ADDR_RST    8'h00
`define MIDS_BITCNT_ACK  4'h8
`define MIDS_BITCNT_RST  4'h0
// rw bit position in the slave address byte
`define MIDS_RW_BIT      0
`endif

// ---- verilog/mids_sync.v ----
`timescale 1ns/1ps
// three-stage sampler; output moves only when stages two and three agree
module mids_sync (
  input  wire mclk,
  input  wire rstn,
  input  wire pin_i,
  output reg  level_q
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s1_q    <= 1'b1;
      s2_q    <= 1'b1;
      s3_q    <= 1'b1;
      level_q <= 1'b1;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_q <= s3_q;
      end
    end
  end
endmodule

// ---- verilog/mids_slave.v ----
`timescale 1ns/1ps
`include "mids_map.vh"
// Notes on behaviour
// - data changes only while serial clock low
// - start begins command; idle until start seen
// - stop after read returns slave to standby
// - transmitter releases; receiver acks ninth clock
// - address match gives ack, then read/write
// - read: acked byte without stop sends next
// - no ack ends read; stop gives standby
// - write: ack every byte until stop
// - upper four address bits match type code
// - next three bits match strap inputs
// - direction bit one reads, zero writes
// - counter holds last accessed location plus one
// - current read: ack, eight bits, no-ack, stop
// - sequential read counter wraps 255 to 0
module mids_slave (
  input  wire       mclk,
  input  wire       rstn,
  input  wire       scl_i,
  input  wire       sda_i,
  output reg        sda_o,
  output reg        sda_oe,
  input  wire       strap_addr_bit0,
  input  wire       strap_addr_bit1,
  input  wire       strap_addr_bit2,
  output reg        standby_q,
  output reg  [7:0] addr_cnt_q
);
  // ************************************************************
  // states
  // ************************************************************
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_DEVA  = 3'h1;
  localparam [2:0] ST_WADR  = 3'h2;
  localparam [2:0] ST_WDAT  = 3'h3;
  localparam [2:0] ST_RDAT  = 3'h4;
  localparam [2:0] ST_RACK  = 3'h5;

  // ************************************************************
  // pin sampling and edge finding
  // ************************************************************
  wire scl_s;
  wire sda_s;
  reg  scl_p_q;
  reg  sda_p_q;
  mids_sync u_scl (.mclk(mclk), .rstn(rstn), .pin_i(scl_i), .level_q(scl_s));
  mids_sync u_sda (.mclk(mclk), .rstn(rstn), .pin_i(sda_i), .level_q(sda_s));

  // straps are board pins; sampled like the bus so a slow strap cannot glitch a match
  wire sa0_s;
  wire sa1_s;
  wire sa2_s;
  mids_sync u_sa0 (.mclk(mclk), .rstn(rstn), .pin_i(strap_addr_bit0), .level_q(sa0_s));
  mids_sync u_sa1 (.mclk(mclk), .rstn(rstn), .pin_i(strap_addr_bit1), .level_q(sa1_s));
  mids_sync u_sa2 (.mclk(mclk), .rstn(rstn), .pin_i(strap_addr_bit2), .level_q(sa2_s));

  wire scl_rise = scl_s & ~scl_p_q;
  wire scl_fall = ~scl_s & scl_p_q;
  // data moving under a high clock is framing, never data
  wire start_ev = scl_s & scl_p_q & sda_p_q & ~sda_s;
  wire stop_ev  = scl_s & scl_p_q & ~sda_p_q & sda_s;

  // ************************************************************
  // storage
  // ************************************************************
  reg [7:0] mem_q [0:`MIDS_DEPTH-1];
  reg [2:0] st_q;
  reg [3:0] bit_q;
  reg [7:0] sh_q;
  reg       ack_ph_q;
  reg       was_rd_q;

  function [7:0] inc8;
    input [7:0] a;
    begin
      inc8 = a + 8'h01;
    end
  endfunction

  // ************************************************************
  // address match
  // ************************************************************
  function addr_hit;
    input [7:0] b;
    input [2:0] s;
    begin
      addr_hit = (b[7:4] == `MIDS_TYPE_CODE)
               & (b[3:1] == s);
    end
  endfunction

  wire [2:0] strap   = {sa2_s, sa1_s, sa0_s};
  wire [7:0] rx_byte = {sh_q[6:0], sda_s};
  wire       dev_hit = addr_hit(sh_q, strap);

  // ************************************************************
  // memory write
  // ************************************************************
  integer i;
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (i = 0; i < `MIDS_DEPTH; i = i + 1) begin
        mem_q[i] <= 8'h00;
      end
    end else if (st_q == ST_WDAT && scl_rise && !ack_ph_q && bit_q == 4'h7) begin
      mem_q[addr_cnt_q] <= rx_byte;
    end
  end

  // ************************************************************
  // bus engine
  // ************************************************************
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      scl_p_q    <= 1'b1;
      sda_p_q    <= 1'b1;
      st_q       <= ST_IDLE;
      bit_q      <= `MIDS_BITCNT_RST;
      sh_q       <= 8'h00;
      ack_ph_q   <= 1'b0;
      was_rd_q   <= 1'b0;
      sda_o      <= 1'b0;
      sda_oe     <= 1'b0;
      standby_q  <= 1'b1;
      addr_cnt_q <= `MIDS_ADDR_RST;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
      if (start_ev) begin
        // repeated start keeps the counter, so a dummy write sets it
        st_q      <= ST_DEVA;
        bit_q     <= `MIDS_BITCNT_RST;
        ack_ph_q  <= 1'b0;
        sda_oe    <= 1'b0;
        standby_q <= 1'b0;
      end else if (stop_ev) begin
        st_q      <= ST_IDLE;
        sda_oe    <= 1'b0;
        standby_q <= 1'b1;
        was_rd_q  <= 1'b0;
      end else begin
        case (st_q)
          ST_IDLE: begin
            sda_oe <= 1'b0;
          end
          ST_DEVA, ST_WADR, ST_WDAT: begin
            if (scl_rise && !ack_ph_q) begin
              sh_q  <= rx_byte;
              bit_q <= bit_q + 4'h1;
              if (bit_q == 4'h7) begin
                ack_ph_q <= 1'b1;
                if (st_q == ST_WADR) begin
                  addr_cnt_q <= rx_byte;
                end else if (st_q == ST_WDAT) begin
                  addr_cnt_q <= inc8(addr_cnt_q);
                end
              end
            end else if (scl_fall && ack_ph_q && bit_q == `MIDS_BITCNT_ACK) begin
              if (st_q == ST_DEVA && !dev_hit) begin
                st_q <= ST_IDLE;
              end else begin
                sda_o  <= 1'b0;
                sda_oe <= 1'b1;
                bit_q  <= bit_q + 4'h1;
              end
            end else if (scl_fall && ack_ph_q) begin
              bit_q    <= `MIDS_BITCNT_RST;
              ack_ph_q <= 1'b0;
              if (st_q == ST_DEVA && sh_q[`MIDS_RW_BIT]) begin
                // read: first data bit goes out on this same low phase
                st_q     <= ST_RDAT;
                was_rd_q <= 1'b1;
                sh_q     <= {mem_q[addr_cnt_q][6:0], 1'b0};
                sda_o    <= mem_q[addr_cnt_q][7];
                sda_oe   <= ~mem_q[addr_cnt_q][7];
                addr_cnt_q <= inc8(addr_cnt_q);
              end else begin
                sda_oe <= 1'b0;
                st_q   <= (st_q == ST_DEVA) ? ST_WADR : ST_WDAT;
              end
            end
          end
          ST_RDAT: begin
            if (scl_fall) begin
              if (bit_q == 4'h7) begin
                sda_oe <= 1'b0;
                st_q   <= ST_RACK;
                bit_q  <= `MIDS_BITCNT_RST;
              end else begin
                // open drain: a one is a released line
                sda_o  <= sh_q[7];
                sda_oe <= ~sh_q[7];
                sh_q   <= {sh_q[6:0], 1'b0};
                bit_q  <= bit_q + 4'h1;
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              if (sda_s) begin
                st_q <= ST_IDLE;
              end else begin
                sh_q <= mem_q[addr_cnt_q];
                addr_cnt_q <= inc8(addr_cnt_q);
                bit_q <= 4'h9;
              end
            end else if (scl_fall && bit_q == 4'h9) begin
              st_q   <= ST_RDAT;
              bit_q  <= `MIDS_BITCNT_RST;
              sda_o  <= sh_q[7];
              sda_oe <= ~sh_q[7];
              sh_q   <= {sh_q[6:0], 1'b0};
            end
          end
          default: st_q <= ST_IDLE;
        endcase
      end
    end
  end
endmodule

// ---- test/mids_master.sv ----
`timescale 1ns/1ps
module mids_master (
  input  wire mclk,
  input  wire sda_w,
  output reg  scl,
  output reg  sda_m
);
  // sda_m high means released; the pull-up gives the wire its high level
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task tick(input integer n);
    repeat (n) @(posedge mclk);
  endtask
  // data moves mid-low so the slave sampler never sees it near an scl edge
  task bit_x(input b, output r);
    begin
      scl <= 1'b0;
      tick(4);
      sda_m <= b;
      tick(4);
      scl <= 1'b1;
      tick(4);
      r = sda_w;
      tick(4);
    end
  endtask
  task start;
    begin
      scl <= 1'b0;
      tick(4);
      sda_m <= 1'b1;
      tick(4);
      scl <= 1'b1;
      tick(8);
      sda_m <= 1'b0;
      tick(8);
    end
  endtask
  task stop;
    begin
      scl <= 1'b0;
      tick(4);
      sda_m <= 1'b0;
      tick(4);
      scl <= 1'b1;
      tick(8);
      sda_m <= 1'b1;
      tick(16);
    end
  endtask
  task xfer(input [7:0] d, input a_in, output [7:0] q, output ack);
    integer k;
    reg     r;
    begin
      for (k = 7; k >= 0; k = k - 1) begin
        bit_x(d[k], r);
        q[k] = r;
      end
      bit_x(a_in, r);
      ack = ~r;
    end
  endtask
endmodule

// ---- test/mids_slave_properties.sv ----
`timescale 1ns/1ps
module mids_slave_properties (
  input wire       mclk,
  input wire       rstn,
  input wire       scl_i,
  input wire       sda_i,
  input wire       sda_o,
  input wire       sda_oe,
  input wire       standby_q,
  input wire [7:0] addr_cnt_q
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  sequence start_seen;
    scl_i && $fell(sda_i);
  endsequence
  sequence stop_seen;
    scl_i && $rose(sda_i);
  endsequence
  a_open_drain_low: assert property (sda_oe |-> !sda_o)
    else $error("data line driven high");
  a_oe_moves_low: assert property ($changed(sda_oe) |-> !scl_i)
    else $error("drive changed while clock high");
  a_oe_holds_high: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe))
    else $error("drive not steady in clock high");
  a_start_wakes: assert property (start_seen |-> ##[1:12] !standby_q)
    else $error("start not taken");
  a_wake_on_start: assert property ($fell(standby_q) |-> scl_i)
    else $error("left standby without start");
  a_stop_sleeps: assert property (stop_seen |-> ##[1:12] standby_q)
    else $error("stop did not give standby");
  a_standby_quiet: assert property (standby_q |-> !sda_oe)
    else $error("drive in standby");
  a_cnt_idle: assert property (standby_q && $past(standby_q) |-> $stable(addr_cnt_q))
    else $error("counter moved in standby");
endmodule
bind mids_slave mids_slave_properties u_props (.mclk(mclk), .rstn(rstn), .scl_i(scl_i),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .standby_q(standby_q), .addr_cnt_q(addr_cnt_q));

// ---- test/test_mids_slave.sv ----
`timescale 1ns/1ps
`include "mids_map.vh"
`define CHK(a, b, m) begin total_checks = total_checks + 1; if ((a) !== (b)) begin \
  error_cnt = error_cnt + 1; $display("CHECK FAILED %0t %s", $time, m); end end
module test_mids_slave;
  reg        mclk = 1'b0;
  reg        rstn = 1'b0;
  reg  [2:0] strap = 3'h0;
  wire       scl, sda_m, sda_o, sda_oe, standby_q;
  wire [7:0] addr_cnt_q;
  wire       sda_w = sda_m & ~sda_oe;
  reg  [7:0] mem [0:255];
  reg  [7:0] cnt, q, d;
  reg        ak;
  reg [31:0] rnd;
  integer    seed = 32'hf65f5875, error_cnt = 0, total_checks = 0, i;
  always #2 mclk = ~mclk;
  mids_slave dut (.mclk(mclk), .rstn(rstn), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe(sda_oe), .strap_addr_bit0(strap[0]), .strap_addr_bit1(strap[1]),
    .strap_addr_bit2(strap[2]), .standby_q(standby_q), .addr_cnt_q(addr_cnt_q));
  mids_master m (.mclk(mclk), .sda_w(sda_w), .scl(scl), .sda_m(sda_m));
  function [7:0] sla(input rd);
    sla = {`MIDS_TYPE_CODE, strap, rd};
  endfunction
  task wr_seq(input [7:0] w, input integer n);
    begin
      m.start;
      m.xfer(sla(1'b0), 1'b1, q, ak);
      `CHK(ak, 1'b1, "address ack")
      m.xfer(w, 1'b1, q, ak);
      `CHK(ak, 1'b1, "word address ack")
      cnt = w;
      for (i = 0; i < n; i = i + 1) begin
        rnd = $random(seed);
        d = rnd[7:0];
        m.xfer(d, 1'b1, q, ak);
        `CHK(ak, 1'b1, "data ack")
        mem[cnt] = d;
        cnt = cnt + 1;
      end
      m.stop;
      `CHK(addr_cnt_q, cnt, "write counter")
    end
  endtask
  task rd_seq(input integer n);
    begin
      m.xfer(sla(1'b1), 1'b1, q, ak);
      `CHK(ak, 1'b1, "read address ack")
      for (i = 0; i < n; i = i + 1) begin
        m.xfer(8'hFF, i == n - 1, q, ak);
        `CHK(q, mem[cnt], "read data")
        cnt = cnt + 1;
      end
      m.stop;
      `CHK(addr_cnt_q, cnt, "read counter")
      `CHK(standby_q, 1'b1, "standby after read")
    end
  endtask
  task tally_and_finish;
    begin
      if (error_cnt == 0 && total_checks > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  // generous bound: whole sequence is a few thousand clocks
  initial begin
    #200000;
    error_cnt = error_cnt + 1;
    tally_and_finish;
  end
  initial begin
    for (i = 0; i < 256; i = i + 1)
      mem[i] = 8'h00;
    @(posedge mclk);
    rnd = $random(seed);
    strap <= rnd[2:0];
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    repeat (6) @(posedge mclk);
    `CHK(standby_q, 1'b1, "reset standby")
    `CHK(addr_cnt_q, 8'h00, "reset counter")
    wr_seq(8'hFE, 3);
    m.start;
    m.xfer(sla(1'b0), 1'b1, q, ak);
    m.xfer(8'hFE, 1'b1, q, ak);
    `CHK(ak, 1'b1, "dummy word ack")
    cnt = 8'hFE;
    m.start;
    rd_seq(3);
    m.start;
    rd_seq(1);
    rnd = $random(seed);
    wr_seq(rnd[7:0], 2);
    m.start;
    rd_seq(2);
    m.start;
    m.xfer(sla(1'b0) ^ 8'h02, 1'b1, q, ak);
    `CHK(ak, 1'b0, "strap mismatch ack")
    m.xfer(8'h00, 1'b1, q, ak);
    `CHK(ak, 1'b0, "ignored byte ack")
    m.start;
    m.xfer(sla(1'b1) ^ 8'h80, 1'b1, q, ak);
    `CHK(ak, 1'b0, "type mismatch ack")
    m.stop;
    `CHK(addr_cnt_q, cnt, "counter after mismatch")
    tally_and_finish;
  end
endmodule
